// ==== design/qpw_params.svh ====
/*
  Constants of the quadrature and pulse-width counter block: register offsets,
  reset values and clock rates.
  Assumes inclusion by the counter module.
*/
// Behaviour
// - Two 32-bit counters, up/down and pulse-width, run together and independently.
// - Up/down counter counts clock-and-direction or four-edge quadrature.
// - Pulse-width counter captures edge times to derive period, duty, high, low.
// - Software sets configuration; results are read from 32-bit latch registers.
// - Up to seven identical blocks, each with its own number for software.
// - Event counter steps only on activity at the two pulse pins.
// - Rising edge on zero_or_capture_pin zeros or latches the counter, by configuration.
// - Clock-direction: each first-pin rise steps by one; second pin 1 up, 0 down.
// - Four-edge: every edge of either quadrature signal makes one step; edges of both in one cycle make none.
// - Four-edge direction follows the order of edges on the two signals.
// - Each pulse pin may be inverted, changing counting edge and direction.
// - Each counter has its own clear and enable control.
// - Pulse-width counter advances on the 100 MHz reference clock.
// - Clock-direction mode accepts first-pin rises up to 20 MHz.
// - Rise stores counter in newest rise latch; reference rise shifts older stages.
// - Pulse-width latch capture by software only; selected pin and polarity steer the edge latches; the code ignores inv_a and inv_b there.
`ifndef QPW_PARAMS_SVH
`define QPW_PARAMS_SVH

`define QPW_OFF_MODE      8'h00
`define QPW_OFF_CTRL      8'h04
`define QPW_OFF_EVT_LATCH 8'h08
`define QPW_OFF_PW_LATCH  8'h0C
`define QPW_OFF_RISE1     8'h10
`define QPW_OFF_RISE2     8'h14
`define QPW_OFF_RISE3     8'h18
`define QPW_OFF_FALL1     8'h1C
`define QPW_OFF_FALL2     8'h20
`define QPW_OFF_FALL3     8'h24
`define QPW_OFF_STATUS    8'h28
`define QPW_OFF_ID        8'h2C
`define QPW_OFF_EVT_LIVE  8'h30

`define QPW_MODE_RESET    8'h00
`define QPW_CTRL_RESET    4'h0

`define QPW_REF_CLK_MHZ   100
`define QPW_MAX_CLK_MHZ   20

`endif

// ==== design/qpw_pkg.sv ====
/*
  Types of the quadrature and pulse-width counter block.
  Assumes the constants header beside it.
*/
package qpw_pkg;

  typedef struct packed {
    logic       pw_pin_b;
    logic       pw_rise_ref;
    logic       zc_enable;
    logic       zc_capture;
    logic       inv_b;
    logic       inv_a;
    logic       zc_zeroes;
    logic       four_edge;
  } mode_t;

  typedef struct packed {
    logic       htrans_act;
    logic       hwrite;
    logic [7:0] haddr;
  } ahb_req_t;

  typedef struct packed {
    logic [2:0] a;
    logic [2:0] b;
    logic [2:0] z;
  } sync_t;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b10
  } bus_state_t;

  typedef struct packed {
    bus_state_t  bus;
    logic [7:0]  addr;
    logic [31:0] rdata;
    mode_t       mode;
    logic        evt_en;
    logic        pw_en;
    logic [31:0] evt_cnt;
    logic [31:0] evt_latch;
    logic [31:0] pw_latch;
    logic [31:0] rise1;
    logic [31:0] rise2;
    logic [31:0] rise3;
    logic [31:0] fall1;
    logic [31:0] fall2;
    logic [31:0] fall3;
    logic [1:0]  pw_cap_sync;
    logic        pw_cap_last;
    logic        pw_clr_tgl;
    logic        pw_cap_tgl;
    sync_t       pin;
    logic [1:0]  edges;
    logic [31:0] snap_s1;
    logic [31:0] snap_s2;
  } state_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic [31:0] snap;
    logic        clr_tgl;
    logic        cap_tgl;
    logic [1:0]  clr_sync;
    logic [1:0]  cap_sync;
    logic        clr_last;
    logic        cap_last;
    logic [1:0]  en_sync;
  } ref_state_t;

endpackage : qpw_pkg

// ==== design/qpw_counter.sv ====
/*
  One counter block: an up/down event counter on mclk and a pulse-width
  counter on the reference clock, with latches reached over AHB-Lite.
  Assumes a 100 MHz reference clock on ref_clk and unsynchronised pins.
*/
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "qpw_params.svh"

module qpw_counter #(
  parameter logic [2:0]  BLOCK_NUMBER = 3'h1,
  parameter logic [15:0] ID_CODE      = 16'hA5C3  // Arbitrary identification value.
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ref_clk,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        pulse_a,
  input  wire logic        pulse_b,
  input  wire logic        zero_or_capture_pin
);
  import qpw_pkg::*;

  if (BLOCK_NUMBER == 3'h0) begin : g_number_check
    $error("BLOCK_NUMBER must lie in 1 to 7");
  end

  state_t     q;
  state_t     d;
  ref_state_t rq;
  ref_state_t rd;

  logic       a_lvl;
  logic       b_lvl;
  logic       a_prev;
  logic       b_prev;
  logic       a_rise;
  logic       a_edge;
  logic       b_edge;
  logic       z_rise;
  logic       pw_sel;
  logic       pw_sel_prev;
  logic       pw_rise;
  logic       pw_fall;
  logic       pw_cap_evt;
  logic [1:0] step;
  logic       cyc_wr;
  logic [31:0] snap_bin;

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection.
  // ----------------------------------------------------------------------
  assign a_lvl       = q.pin.a[1] ^ q.mode.inv_a;
  assign b_lvl       = q.pin.b[1] ^ q.mode.inv_b;
  assign a_prev      = q.pin.a[2] ^ q.mode.inv_a;
  assign b_prev      = q.pin.b[2] ^ q.mode.inv_b;
  assign a_rise      = a_lvl & ~a_prev;
  assign a_edge      = a_lvl ^ a_prev;
  assign b_edge      = b_lvl ^ b_prev;
  assign z_rise      = q.pin.z[1] & ~q.pin.z[2];
  assign pw_sel      = q.mode.pw_pin_b ? q.pin.b[1] : q.pin.a[1];
  assign pw_sel_prev = q.mode.pw_pin_b ? q.pin.b[2] : q.pin.a[2];
  assign pw_rise     = pw_sel & ~pw_sel_prev;
  assign pw_fall     = ~pw_sel & pw_sel_prev;
  assign pw_cap_evt  = q.pw_cap_sync[1] ^ q.pw_cap_last;

  // The reference snapshot arrives in Gray code and is turned back to binary.
  // A pulse-width clear jumps several bits at once, so a capture taken within
  // a few cycles of that clear may see a stale value.
  for (genvar gi = 0; gi < 32; gi++) begin : g_gray
    assign snap_bin[gi] = ^(q.snap_s2 >> gi);
  end

  // Step direction: clock-direction follows the second pin; four-edge follows which signal leads.
  always_comb begin
    step = 2'b00;
    if (!q.mode.four_edge) begin
      if (a_rise) begin
        step = b_lvl ? 2'b01 : 2'b11;
      end
    end else if (a_edge ^ b_edge) begin
      step = ((a_edge && (a_lvl != b_lvl)) || (b_edge && (a_lvl == b_lvl)))
             ? 2'b01 : 2'b11;
    end
  end

  assign cyc_wr = (q.bus == BUS_WRITE);

  // ----------------------------------------------------------------------
  // System-clock next state.
  // ----------------------------------------------------------------------
  always_comb begin
    d           = q;
    d.pin.a     = {q.pin.a[1:0], pulse_a};
    d.pin.b     = {q.pin.b[1:0], pulse_b};
    d.pin.z     = {q.pin.z[1:0], zero_or_capture_pin};
    d.pw_cap_sync = {q.pw_cap_sync[0], rq.cap_tgl};
    d.pw_cap_last = q.pw_cap_sync[1];
    d.edges     = {pw_fall, pw_rise};
    d.snap_s1   = rq.snap;
    d.snap_s2   = q.snap_s1;

    if (q.evt_en) begin
      unique case (step)
        2'b01:   d.evt_cnt = q.evt_cnt + 32'h0000_0001;
        2'b11:   d.evt_cnt = q.evt_cnt - 32'h0000_0001;
        default: d.evt_cnt = q.evt_cnt;
      endcase
    end
    if (q.mode.zc_enable && z_rise) begin
      if (q.mode.zc_capture) begin
        d.evt_latch = q.evt_cnt;
      end else if (q.mode.zc_zeroes) begin
        d.evt_cnt = 32'h0000_0000;
      end
    end

    if (pw_cap_evt) begin
      d.pw_latch = snap_bin;
    end
    if (q.pw_en && pw_rise && q.mode.pw_rise_ref == 1'b1) begin
      d.rise1 = snap_bin;
      d.rise2 = q.rise1;
      d.rise3 = q.rise2;
      d.fall2 = q.fall1;
      d.fall3 = q.fall2;
    end else if (q.pw_en && pw_rise) begin
      d.rise1 = snap_bin;
    end
    if (q.pw_en && pw_fall) begin
      d.fall1 = snap_bin;
      if (!q.mode.pw_rise_ref) begin
        d.fall2 = q.fall1;
        d.fall3 = q.fall2;
      end
    end

    // AHB-Lite slave: zero wait states, OKAY always.
    d.bus = BUS_IDLE;
    if (hsel && hready && htrans[1]) begin
      d.addr = haddr[7:0];
      d.bus  = hwrite ? BUS_WRITE : BUS_READ;
    end
    if (cyc_wr) begin
      unique case (q.addr)
        `QPW_OFF_MODE: d.mode = mode_t'(hwdata[7:0]);
        `QPW_OFF_CTRL: begin
          d.evt_en = hwdata[0];
          d.pw_en  = hwdata[1];
          if (hwdata[2]) begin
            d.evt_cnt = 32'h0000_0000;
          end
          if (hwdata[3]) begin
            d.pw_clr_tgl = ~q.pw_clr_tgl;
          end
          if (hwdata[4]) begin
            d.evt_latch = q.evt_cnt;
          end
          if (hwdata[5]) begin
            d.pw_cap_tgl = ~q.pw_cap_tgl;
          end
        end
        default: ;
      endcase
    end
    d.rdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        `QPW_OFF_MODE:      d.rdata = {24'h00_0000, q.mode};
        `QPW_OFF_CTRL:      d.rdata = {30'h0, q.pw_en, q.evt_en};
        `QPW_OFF_EVT_LATCH: d.rdata = q.evt_latch;
        `QPW_OFF_PW_LATCH:  d.rdata = q.pw_latch;
        `QPW_OFF_RISE1:     d.rdata = q.rise1;
        `QPW_OFF_RISE2:     d.rdata = q.rise2;
        `QPW_OFF_RISE3:     d.rdata = q.rise3;
        `QPW_OFF_FALL1:     d.rdata = q.fall1;
        `QPW_OFF_FALL2:     d.rdata = q.fall2;
        `QPW_OFF_FALL3:     d.rdata = q.fall3;
        `QPW_OFF_STATUS:    d.rdata = {29'h0, q.pin.z[1], b_lvl, a_lvl};
        `QPW_OFF_ID:        d.rdata = {13'h0, BLOCK_NUMBER, ID_CODE};
        default:            d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q      <= '0;
      q.mode <= mode_t'(`QPW_MODE_RESET);
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Reference-clock pulse-width counter.
  // ----------------------------------------------------------------------
  always_comb begin
    rd          = rq;
    rd.clr_sync = {rq.clr_sync[0], q.pw_clr_tgl};
    rd.cap_sync = {rq.cap_sync[0], q.pw_cap_tgl};
    rd.en_sync  = {rq.en_sync[0], q.pw_en};
    rd.clr_last = rq.clr_sync[1];
    rd.cap_last = rq.cap_sync[1];
    if (rq.en_sync[1]) begin
      rd.cnt = rq.cnt + 32'h0000_0001;
    end
    if (rq.clr_sync[1] ^ rq.clr_last) begin
      rd.cnt = 32'h0000_0000;
    end
    // Gray code changes one bit per count, so the word may cross to mclk.
    rd.snap = rq.cnt ^ (rq.cnt >> 1);
    if (rq.cap_sync[1] ^ rq.cap_last) begin
      rd.cap_tgl = ~rq.cap_tgl;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rq <= '0;
    end else begin
      rq <= rd;
    end
  end

  assign hrdata    = q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule : qpw_counter

// ==== tb/qpw_counter_assertions.sv ====
/*
  Port checker for qpw_counter: bus answers, fixed reads and pin status.
  Assumes a bind from the bench top that hands on the block's parameters.
*/
`timescale 1ns/1ns
module qpw_counter_assertions #(
  parameter logic [2:0]  BLOCK_NUMBER = 3'h1,
  parameter logic [15:0] ID_CODE      = 16'h0
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        ref_clk,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        pulse_a,
  input wire logic        pulse_b,
  input wire logic        zero_or_capture_pin
);
  logic       rd_t;
  logic [2:0] pins;
  assign rd_t = hsel && hready && htrans[1] && !hwrite;
  assign pins = {zero_or_capture_pin, pulse_b, pulse_a};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ---
  // Checks
  // ---
  ready_always_a: assert property (hreadyout == 1'b1)
    else $error("wait state seen");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("error response seen");
  rdata_idle_a: assert property (!$past(rd_t) |-> hrdata == 32'h0)
    else $error("read data outside a read");
  unmapped_zero_a: assert property ($past(rd_t && haddr[7:0] > 8'h30) |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  block_id_a: assert property ($past(rd_t && haddr[7:0] == 8'h2C)
    |-> hrdata == {13'h0, BLOCK_NUMBER, ID_CODE}) else $error("wrong block number");
  mode_width_a: assert property ($past(rd_t && haddr[7:0] == 8'h00)
    |-> hrdata[31:8] == 24'h0) else $error("mode read too wide");
  ctrl_pulse_a: assert property ($past(rd_t && haddr[7:0] == 8'h04)
    |-> hrdata[31:2] == 30'h0) else $error("control pulse bits read back");
  status_pins_a: assert property ($stable(pins) [*6] ##0 (rd_t && haddr[7:0] == 8'h28)
    |=> hrdata == {29'h0, $past(pins)}) else $error("status differs from pins");
  cover property (rd_t && haddr[7:0] == 8'h2C);
  cover property ($rose(zero_or_capture_pin));
  cover property ($rose(pulse_a) && pulse_b);
  cover property (rd_t && haddr[7:0] == 8'h0C);
endmodule : qpw_counter_assertions

// ==== tb/qpw_signal_source.sv ====
/*
  Far-side pin source: bursts, clock-and-direction and quadrature waves.
  Assumes the bench lets the block settle after each burst.
*/
`timescale 1ns/1ns
module qpw_signal_source (
  output logic a,
  output logic b,
  output logic z
);
  initial begin
    a = 1'b0;
    b = 1'b0;
    z = 1'b0;
  end
  task pulses(input int n, input int hi, input int lo);
    repeat (n) begin
      a <= 1'b1;
      #hi;
      a <= 1'b0;
      #lo;
    end
  endtask : pulses
  // Falling edges lead: each pass lowers b, then raises it again.
  task bpulses(input int n, input int hi, input int lo);
    repeat (n) begin
      b <= 1'b0;
      #lo;
      b <= 1'b1;
      #hi;
    end
  endtask : bpulses
  task clk_dir(input logic dir, input int n);
    b <= dir;
    #30;
    pulses(n, 25, 25);
  endtask : clk_dir
  // Each pass gives two edges a quarter period apart.
  task quad(input logic fwd, input int n);
    repeat (n) begin
      if (fwd) a <= ~a; else b <= ~b;
      #40;
      if (fwd) b <= ~b; else a <= ~a;
      #40;
    end
  endtask : quad
  task zpulse;
    z <= 1'b1;
    #100;
    z <= 1'b0;
    #100;
  endtask : zpulse
endmodule : qpw_signal_source

// ==== tb/test_qpw_counter.sv ====
/*
  Bench for qpw_counter: AHB-Lite tasks, pin scenarios and the verdict.
  Assumes the design, the signal source and the checker are compiled first.
*/
`timescale 1ns/1ns
module test_qpw_counter;
  import qpw_pkg::*;
  localparam int REF_NS = 30;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ref_clk = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, v, r1, r2, r3, f1, f2, f3;
  logic        hreadyout, hresp, pulse_a, pulse_b, zc;
  int          err_total = 0;
  int          comparisons = 0;
  always #5 mclk = ~mclk;
  initial begin
    #7;
    forever #15 ref_clk = ~ref_clk;
  end
  qpw_counter #(.BLOCK_NUMBER(3'h5), .ID_CODE(16'h3C96)) u_qpw_counter (
    .mclk(mclk), .rst_n(rst_n), .ref_clk(ref_clk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pulse_a(pulse_a), .pulse_b(pulse_b), .zero_or_capture_pin(zc));
  qpw_signal_source u_signal_source (.a(pulse_a), .b(pulse_b), .z(zc));
  // ---
  // Tasks
  // ---
  task cmp32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp32
  task near(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (^got === 1'bx || got - exp + 32'h1 > 32'h2) begin
      err_total++;
      $display("unexpected at %0t: got %h, near %h", $time, got, exp);
    end
  endtask : near
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd
  task rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    cmp32(q, e);
  endtask : rdc
  task grab(output logic [31:0] q);
    repeat (6) @(posedge mclk);
    wr(8'h04, 32'h11);
    rd(8'h08, q);
  endtask : grab
  task test_done;
    $display("mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial begin
    #300000;
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done;
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rdc(8'h40, 32'h0);
    rdc(8'h2C, {13'h0, 3'h5, 16'h3C96});
    wr(8'h04, 32'h5);
    u_signal_source.clk_dir(1'b1, 5);
    u_signal_source.clk_dir(1'b0, 2);
    grab(v);
    cmp32(v, 32'h3);
    wr(8'h00, 32'h08);
    u_signal_source.clk_dir(1'b1, 4);
    grab(v);
    cmp32(v, 32'hFFFFFFFF);
    wr(8'h04, 32'h0);
    u_signal_source.clk_dir(1'b1, 3);
    grab(v);
    cmp32(v, 32'hFFFFFFFF);
    wr(8'h04, 32'h5);
    grab(v);
    cmp32(v, 32'h0);
    wr(8'h00, 32'h30);
    u_signal_source.clk_dir(1'b1, 2);
    u_signal_source.zpulse;
    repeat (6) @(posedge mclk);
    rdc(8'h08, 32'h2);
    wr(8'h00, 32'h22);
    u_signal_source.zpulse;
    grab(v);
    cmp32(v, 32'h0);
    rdc(8'h00, 32'h22);
    rdc(8'h28, {29'h0, zc, pulse_b, pulse_a});
    wr(8'h00, 32'h01);
    wr(8'h04, 32'h5);
    u_signal_source.quad(1'b1, 6);
    u_signal_source.quad(1'b0, 2);
    grab(v);
    cmp32(v, 32'hFFFFFFF8);
    wr(8'h00, 32'h05);
    wr(8'h04, 32'h5);
    u_signal_source.quad(1'b0, 2);
    grab(v);
    cmp32(v, 32'hFFFFFFFC);
    wr(8'h00, 32'h40);
    wr(8'h04, 32'h2);
    u_signal_source.pulses(4, 8 * REF_NS, 12 * REF_NS);
    repeat (10) @(posedge mclk);
    rd(8'h14, r2);
    rd(8'h18, r3);
    rd(8'h24, f3);
    near(r2 - r3, 32'h14);
    near(f3 - r3, 32'h8);
    wr(8'h04, 32'h22);
    repeat (20) @(posedge mclk);
    rd(8'h0C, v);
    cmp32({31'h0, v > r2}, 32'h1);
    u_signal_source.pulses(1, 100, 100);
    repeat (10) @(posedge mclk);
    rdc(8'h0C, v);
    wr(8'h00, 32'h80);
    u_signal_source.bpulses(4, 8 * REF_NS, 12 * REF_NS);
    repeat (10) @(posedge mclk);
    rd(8'h10, r1);
    rd(8'h1C, f1);
    rd(8'h20, f2);
    rd(8'h24, f3);
    near(f2 - f3, 32'h14);
    near(r1 - f1, 32'hC);
    wr(8'h04, 32'h08);
    repeat (20) @(posedge mclk);
    wr(8'h04, 32'h20);
    repeat (20) @(posedge mclk);
    rdc(8'h0C, 32'h0);
    test_done;
  end
endmodule : test_qpw_counter
bind qpw_counter qpw_counter_assertions #(.BLOCK_NUMBER(BLOCK_NUMBER), .ID_CODE(ID_CODE))
  u_qpw_counter_assertions (.mclk(mclk), .rst_n(rst_n), .ref_clk(ref_clk), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .pulse_a(pulse_a), .pulse_b(pulse_b), .zero_or_capture_pin(zero_or_capture_pin));
